// ===== address_relocation_window.sv
// Design decisions made here: strobed register access and the register addresses.
`timescale 1ns/100ps
module address_relocation_window (
  input  wire logic                                  CLOCK_IN,
  input  wire logic                                  SRST_IN,
  input  wire logic                                  CE_IN,
  input  wire logic [addr_reloc_pkg::BASE_W-1:0]     IO_BASE_IN,
  input  wire logic [addr_reloc_pkg::IO_ADDR_W-1:0]  IO_ADDR_IN,
  input  wire logic [addr_reloc_pkg::DATA_W-1:0]     IO_WDATA_IN,
  input  wire logic                                  IO_WR_IN,
  input  wire logic                                  IO_RD_IN,
  output logic      [addr_reloc_pkg::DATA_W-1:0]     IO_RDATA_OUT,
  input  wire logic [addr_reloc_pkg::LOG_ADDR_W-1:0] LOG_ADDR_IN,
  output logic      [addr_reloc_pkg::PHYS_ADDR_W-1:0] PHYS_ADDR_OUT,
  output logic                                       WINDOW_HIT_OUT
);
  import addr_reloc_pkg::*;

  // Base strap synchroniser: three stages, change taken when last two agree
  logic [BASE_W-1:0] base_s1_q;
  logic [BASE_W-1:0] base_s2_q;
  logic [BASE_W-1:0] base_s3_q;
  logic [BASE_W-1:0] io_base_q;
  logic [BASE_W-1:0] io_base_d;

  // Register file
  logic [DATA_W-1:0] config_q;
  logic [DATA_W-1:0] config_d;
  logic [DATA_W-1:0] page0_q;
  logic [DATA_W-1:0] page0_d;
  logic [DATA_W-1:0] page1_q;
  logic [DATA_W-1:0] page1_d;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;

  // Translation outputs
  logic [PHYS_ADDR_W-1:0] phys_q;
  logic [PHYS_ADDR_W-1:0] phys_d;
  logic                   hit_q;
  logic                   hit_d;

  logic              block_sel;
  logic [1:0]        port_ofs;
  logic [DATA_W-1:0] config_wr_val;

  logic              translator_master_enable;
  logic              page_count_select_b;
  logic              window_bit12_match;
  logic              window_bit13_match;
  logic              window_bit14_match;
  logic              window_bit15_match;
  logic              window_match;
  logic [DATA_W-1:0] page_sel;

  // Window start bits 15 down to 12 and which of them take part
  logic [3:0]        window_cfg;
  logic [3:0]        window_bit_eq;
  logic [3:0]        window_bit_used;

  // Decoded strobes, one write and one read strobe per register port
  logic              cfg_wr_sel;
  logic              page0_wr_sel;
  logic              page1_wr_sel;
  logic              cfg_rd_sel;
  logic              page0_rd_sel;
  logic              page1_rd_sel;

  always_comb begin
    io_base_d = io_base_q;
    if (base_s2_q == base_s3_q) begin
      io_base_d = base_s3_q;
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    if (SRST_IN) begin
      base_s1_q <= '0;
      base_s2_q <= '0;
      base_s3_q <= '0;
    end else if (CE_IN) begin
      base_s1_q <= IO_BASE_IN;
      base_s2_q <= base_s1_q;
      base_s3_q <= base_s2_q;
    end
  end

  // Base defaults to the strap value shortly after reset; a strap is not
  // meant to move while running, but a settled change is still followed.
  always_ff @(posedge CLOCK_IN) begin
    if (SRST_IN) begin
      io_base_q <= '0;
    end else if (CE_IN) begin
      io_base_q <= io_base_d;
    end
  end

  always_comb begin
    block_sel = (IO_ADDR_IN[IO_ADDR_W-1:2] == io_base_q);
    port_ofs  = IO_ADDR_IN[1:0];
  end

  always_comb begin
    config_wr_val = IO_WDATA_IN & CFG_USED_MASK;
    if (config_wr_val[CFG_TWO_PAGE_BIT]) begin
      config_wr_val[CFG_WIN12_BIT] = 1'b0;
    end
  end

  always_comb begin
    cfg_wr_sel   = IO_WR_IN && block_sel && (port_ofs == OFS_CONFIG);
    page0_wr_sel = IO_WR_IN && block_sel && (port_ofs == OFS_PAGE0);
    page1_wr_sel = IO_WR_IN && block_sel && (port_ofs == OFS_PAGE1);
    cfg_rd_sel   = IO_RD_IN && block_sel && (port_ofs == OFS_CONFIG);
    page0_rd_sel = IO_RD_IN && block_sel && (port_ofs == OFS_PAGE0);
    page1_rd_sel = IO_RD_IN && block_sel && (port_ofs == OFS_PAGE1);
  end

  always_comb begin
    config_d = config_q;
    if (cfg_wr_sel) begin
      config_d = config_wr_val;
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    if (SRST_IN) begin
      config_q <= CONFIG_RESET;
    end else if (CE_IN) begin
      config_q <= config_d;
    end
  end

  always_comb begin
    page0_d = page0_q;
    page1_d = page1_q;
    if (page0_wr_sel) begin
      page0_d = IO_WDATA_IN;
    end
    if (page1_wr_sel) begin
      page1_d = IO_WDATA_IN;
    end
  end

  // Page registers clear at reset; software must reload them before
  // trusting the window, otherwise every hit lands in the lowest 4 K.
  always_ff @(posedge CLOCK_IN) begin
    if (SRST_IN) begin
      page0_q <= PAGE_RESET;
      page1_q <= PAGE_RESET;
    end else if (CE_IN) begin
      page0_q <= page0_d;
      page1_q <= page1_d;
    end
  end

  // Offset zero and foreign addresses read as zero; no wait states
  always_comb begin
    rdata_d = '0;
    if (cfg_rd_sel) begin
      rdata_d = config_q;
    end
    if (page0_rd_sel) begin
      rdata_d = page0_q;
    end
    if (page1_rd_sel) begin
      rdata_d = page1_q;
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    if (SRST_IN) begin
      rdata_q <= '0;
    end else if (CE_IN) begin
      rdata_q <= rdata_d;
    end
  end

  always_comb begin
    translator_master_enable = config_q[CFG_ENABLE_BIT];
    page_count_select_b      = config_q[CFG_TWO_PAGE_BIT];
    window_bit12_match       = config_q[CFG_WIN12_BIT];
    window_bit13_match       = config_q[CFG_WIN13_BIT];
    window_bit14_match       = config_q[CFG_WIN14_BIT];
    window_bit15_match       = config_q[CFG_WIN15_BIT];
  end

  always_comb begin
    window_cfg = {window_bit15_match, window_bit14_match,
                  window_bit13_match, window_bit12_match};
    window_bit_used = 4'hF;
    if (page_count_select_b) begin
      window_bit_used = 4'hE;
    end
  end

  for (genvar i = 0; i < 4; i++) begin : g_win_bit
    always_comb begin
      window_bit_eq[i] = !window_bit_used[i] ||
                         (LOG_ADDR_IN[PAGE_OFS_W+i] == window_cfg[i]);
    end
  end

  always_comb begin
    window_match = &window_bit_eq;
  end

  always_comb begin
    page_sel = page0_q;
    if (page_count_select_b && LOG_ADDR_IN[12]) begin
      page_sel = page1_q;
    end
  end

  always_comb begin
    hit_d = translator_master_enable && window_match;
  end

  // Registered outputs cost one cycle of latency but keep the memory
  // bus free of glitches while the logical address settles.
  always_comb begin
    phys_d = {{(PHYS_ADDR_W-LOG_ADDR_W){1'b0}}, LOG_ADDR_IN};
    if (hit_d) begin
      phys_d = {PHYS_HI_PAD, page_sel,
                LOG_ADDR_IN[PAGE_OFS_W-1:0]};
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    if (SRST_IN) begin
      phys_q <= '0;
    end else if (CE_IN) begin
      phys_q <= phys_d;
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    if (SRST_IN) begin
      hit_q <= 1'b0;
    end else if (CE_IN) begin
      hit_q <= hit_d;
    end
  end

  assign IO_RDATA_OUT   = rdata_q;
  assign PHYS_ADDR_OUT  = phys_q;
  assign WINDOW_HIT_OUT = hit_q;

endmodule

// ===== addr_reloc_pkg.sv
package addr_reloc_pkg;

  localparam int unsigned IO_ADDR_W   = 8;
  localparam int unsigned DATA_W      = 8;
  localparam int unsigned LOG_ADDR_W  = 16;
  localparam int unsigned PHYS_ADDR_W = 24;
  localparam int unsigned PAGE_OFS_W  = 12;
  localparam int unsigned BASE_W      = 6;

  // I/O port offsets inside the decoded block
  localparam logic [1:0] OFS_CONFIG = 2'h1;
  localparam logic [1:0] OFS_PAGE0  = 2'h2;
  localparam logic [1:0] OFS_PAGE1  = 2'h3;

  // Configuration register field positions
  localparam int unsigned CFG_ENABLE_BIT    = 0;
  localparam int unsigned CFG_TWO_PAGE_BIT  = 1;
  localparam int unsigned CFG_WIN12_BIT     = 2;
  localparam int unsigned CFG_WIN13_BIT     = 3;
  localparam int unsigned CFG_WIN14_BIT     = 4;
  localparam int unsigned CFG_WIN15_BIT     = 5;
  localparam logic [7:0]  CFG_USED_MASK     = 8'h3F;

  // Reset values: two pages at A000, unit disabled
  localparam logic [7:0] CONFIG_RESET = 8'h2A;
  localparam logic [7:0] PAGE_RESET   = 8'h00;
  localparam logic [3:0] PHYS_HI_PAD  = 4'h0;

endpackage

// ===== addr_reloc_properties.sv
`timescale 1ns/100ps
module addr_reloc_checker (
  input wire logic        CLOCK_IN,
  input wire logic        SRST_IN,
  input wire logic        CE_IN,
  input wire logic [5:0]  IO_BASE_IN,
  input wire logic [7:0]  IO_ADDR_IN,
  input wire logic [7:0]  IO_WDATA_IN,
  input wire logic        IO_WR_IN,
  input wire logic        IO_RD_IN,
  input wire logic [7:0]  IO_RDATA_OUT,
  input wire logic [15:0] LOG_ADDR_IN,
  input wire logic [23:0] PHYS_ADDR_OUT,
  input wire logic        WINDOW_HIT_OUT
);
  default clocking @(posedge CLOCK_IN); endclocking
  default disable iff (SRST_IN || !CE_IN);
  AST_MISS_PASSES: assert property (!WINDOW_HIT_OUT |->
    PHYS_ADDR_OUT == {8'h00, $past(LOG_ADDR_IN)}) else $error("miss altered");
  AST_HIT_OFFSET: assert property (WINDOW_HIT_OUT |->
    PHYS_ADDR_OUT[11:0] == $past(LOG_ADDR_IN[11:0])
    && PHYS_ADDR_OUT[23:20] == 4'h0) else $error("hit offset wrong");
  AST_RD_IDLE: assert property (!$past(IO_RD_IN) |->
    IO_RDATA_OUT == 8'h00) else $error("read data outside slot");
  AST_RD_OFS0: assert property (IO_RD_IN && IO_ADDR_IN[1:0] == 2'h0
    |=> IO_RDATA_OUT == 8'h00) else $error("offset zero read");
  AST_RD_FOREIGN: assert property (IO_RD_IN
    && IO_ADDR_IN[7:2] != IO_BASE_IN |=> IO_RDATA_OUT == 8'h00)
    else $error("foreign read answered");
  AST_CFG_BIT12: assert property (IO_RD_IN && IO_ADDR_IN[1:0] == 2'h1
    |=> !(IO_RDATA_OUT[1] && IO_RDATA_OUT[2])) else $error("bit12 set");
  AST_PAGE_ECHO: assert property (IO_WR_IN && IO_ADDR_IN[1]
    && IO_ADDR_IN[7:2] == IO_BASE_IN ##2 IO_RD_IN
    && IO_ADDR_IN == $past(IO_ADDR_IN, 2)
    |=> IO_RDATA_OUT == $past(IO_WDATA_IN, 3)) else $error("page echo");
  AST_SAME_ADDR: assert property ($past(LOG_ADDR_IN) ==
    $past(LOG_ADDR_IN, 2) && !$past(IO_WR_IN, 2) && !$past(IO_WR_IN, 3)
    |-> $stable(PHYS_ADDR_OUT) && $stable(WINDOW_HIT_OUT))
    else $error("unstable translation");
  AST_HIT_WINDOW: assert property (WINDOW_HIT_OUT &&
    $past(WINDOW_HIT_OUT) && !$past(IO_WR_IN, 2) && !$past(IO_WR_IN, 3)
    |-> $past(LOG_ADDR_IN[15:13]) == $past(LOG_ADDR_IN[15:13], 2))
    else $error("hit outside window");
  COV_HIT: cover property (WINDOW_HIT_OUT ##1 !WINDOW_HIT_OUT);
  COV_READ: cover property (IO_RD_IN ##1 IO_RDATA_OUT != 8'h00);
  COV_ECHO: cover property (IO_WR_IN ##2 IO_RD_IN);
endmodule
bind address_relocation_window addr_reloc_checker u_addr_reloc_checker (.*);

// ===== addr_reloc_mem_bus.sv
`timescale 1ns/100ps
module addr_reloc_mem_bus (
  input  wire logic        clk_in,
  input  wire logic [23:0] phys_in,
  input  wire logic        hit_in,
  output logic      [23:0] seen_phys_out,
  output logic             seen_hit_out
);
  // Memory side takes the address as the bus cycle closes
  always_ff @(posedge clk_in) begin
    seen_phys_out <= phys_in;
    seen_hit_out <= hit_in;
  end
endmodule

// ===== address_relocation_window_tb_top.sv
`timescale 1ns/100ps
module address_relocation_window_tb_top;
  import addr_reloc_pkg::*;
  logic clk = 1'b0, srst = 1'b1, ce = 1'b1, wr = 1'b0, rdn = 1'b0, sh, hit;
  logic [5:0] base = 6'h38;
  logic [7:0] ioa = 8'h00, iowd = 8'h00, rd;
  logic [15:0] la = 16'h0000;
  logic [23:0] pa, sp;
  int err_count = 0, samples_checked = 0, cycles = 0;
  initial forever #25 clk = ~clk;
  address_relocation_window u_address_relocation_window (.CLOCK_IN(clk),
    .SRST_IN(srst), .CE_IN(ce), .IO_BASE_IN(base), .IO_ADDR_IN(ioa),
    .IO_WDATA_IN(iowd), .IO_WR_IN(wr), .IO_RD_IN(rdn), .IO_RDATA_OUT(rd),
    .LOG_ADDR_IN(la), .PHYS_ADDR_OUT(pa), .WINDOW_HIT_OUT(hit));
  addr_reloc_mem_bus u_addr_reloc_mem_bus (.clk_in(clk), .phys_in(pa),
    .hit_in(hit), .seen_phys_out(sp), .seen_hit_out(sh));
  task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [1:0] o, input logic [7:0] d);
    @(posedge clk); wr <= 1'b1; ioa <= {base, o}; iowd <= d;
    @(posedge clk); wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk); rdn <= 1'b1; ioa <= a;
    @(posedge clk); rdn <= 1'b0;
    #1 cmp({16'h0000, rd}, {16'h0000, e});
  endtask
  // Memory model adds one stage, so look two edges after the address
  task automatic xl(input logic [15:0] a, input logic [23:0] e, input logic h);
    @(posedge clk); la <= a;
    repeat (2) @(posedge clk);
    #1 cmp(sp, e);
    cmp({23'h0, sh}, {23'h0, h});
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      wrap_up();
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    repeat (5) @(posedge clk);
    rd_reg({base, 2'h2}, PAGE_RESET);
    rd_reg({base, 2'h3}, PAGE_RESET);
    rd_reg({base, 2'h1}, CONFIG_RESET);
    xl(16'hA123, 24'h00A123, 1'b0);
    wr_reg(2'h2, 8'h15);
    wr_reg(2'h3, 8'h40);
    rd_reg({base, 2'h3}, 8'h40);
    rd_reg({base, 2'h0}, 8'h00);
    rd_reg({~base, 2'h3}, 8'h00);
    xl(16'hA123, 24'h00A123, 1'b0);
    wr_reg(2'h1, 8'h2F);
    rd_reg({base, 2'h1}, 8'h2B);
    xl(16'hA123, 24'h015123, 1'b1);
    xl(16'hBFFF, 24'h040FFF, 1'b1);
    xl(16'hC000, 24'h00C000, 1'b0);
    xl(16'h9FFF, 24'h009FFF, 1'b0);
    wr_reg(2'h1, 8'h2D);
    xl(16'hB123, 24'h015123, 1'b1);
    // Clock enable low must hold the last translation
    @(posedge clk);
    ce <= 1'b0;
    la <= 16'hA123;
    repeat (3) @(posedge clk);
    #1 cmp(pa, 24'h015123);
    cmp({23'h0, hit}, 24'h000001);
    @(posedge clk);
    ce <= 1'b1;
    la <= 16'hB123;
    xl(16'hA123, 24'h00A123, 1'b0);
    wr_reg(2'h1, 8'h2C);
    xl(16'hB123, 24'h00B123, 1'b0);
    wrap_up();
  end
endmodule
